// >>> src/lcis_select.v
`include "lcis_regs.vh"

module lcis_select (
  // apb clock and power-on reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // cell-level reset that leaves the control register alone and only sets the sticky status flag
  input  wire        cell_ctrl_clear,
  // cell input bus and selected data signals
  input  wire [15:0] cell_input_bus,
  output wire        selected_data_one,
  output wire        selected_data_two
);

  // field registers and their next values
  reg  [2:0]  first_data_source_select_ff;
  reg  [2:0]  second_data_source_select_ff;
  reg  [2:0]  nxt_first_data_source_select;
  reg  [2:0]  nxt_second_data_source_select;

  // sticky cell-clear flag and its next value
  reg         ctrl_clear_seen_ff;
  reg         nxt_ctrl_clear_seen;

  // registered read data and its next value
  reg  [31:0] prdata_ff;
  reg  [31:0] nxt_prdata;

  // apb phase and address qualifiers
  wire        setup_phase;
  wire        access_phase;
  wire        wr_en;
  wire        rd_en;
  wire        rd_setup;
  wire        sel_low_hit;
  wire        status_hit;

  // register image as software reads it
  wire [7:0]  data_input_select_low;

  // input line number chosen by each field
  wire [3:0]  first_line_idx;
  wire [3:0]  second_line_idx;

  // address decode for the select register; full compare, no aliasing
  function is_sel_low;
    input [11:0] addr;
    begin
      is_sel_low = (addr == `LCIS_SEL_LOW_ADDR);
    end
  endfunction

  // address decode for the status word
  function is_status;
    input [11:0] addr;
    begin
      is_status = (addr == `LCIS_STATUS_ADDR);
    end
  endfunction

  // first field: codes climb from line 0, so code n picks line n
  // low three codes follow the pattern of the upper five
  function [3:0] first_line;
    input [2:0] code;
    begin
      case (code)
        3'h0: first_line = 4'h0;
        3'h1: first_line = 4'h1;
        3'h2: first_line = 4'h2;
        3'h3: first_line = 4'h3;
        3'h4: first_line = 4'h4;
        3'h5: first_line = 4'h5;
        3'h6: first_line = 4'h6;
        3'h7: first_line = 4'h7;
        default: first_line = 4'h0;
      endcase
    end
  endfunction

  // second field: window of eight lines that starts at line 4
  // overlaps the first field on lines 4..7, so both may pick one line
  function [3:0] second_line;
    input [2:0] code;
    begin
      case (code)
        3'h0: second_line = 4'h4;
        3'h1: second_line = 4'h5;
        3'h2: second_line = 4'h6;
        3'h3: second_line = 4'h7;
        3'h4: second_line = 4'h8;
        3'h5: second_line = 4'h9;
        3'h6: second_line = 4'ha;
        3'h7: second_line = 4'hb;
        default: second_line = 4'h4;
      endcase
    end
  endfunction

  // one line out of sixteen; shared by both selectors
  // both tables stay within lines 0..11, so lines 12..15 are never picked here
  function pick_line;
    input [15:0] bus;
    input [3:0]  idx;
    begin
      pick_line = bus[idx];
    end
  endfunction

  // apb phase decode: setup is psel alone, access is psel with penable
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_en        = access_phase & pwrite;
  assign rd_en        = access_phase & ~pwrite;
  assign rd_setup     = setup_phase & ~pwrite;
  assign sel_low_hit  = is_sel_low(paddr);
  assign status_hit   = is_status(paddr);

  // zero wait state slave, so pready never stalls a master
  // unmapped addresses answer with an error and change nothing
  // pslverr only stands during the access phase
  assign pready  = 1'h1;
  assign pslverr = access_phase & ~sel_low_hit & ~status_hit;

  // write lands only with lane 0 strobed; writes on upper lanes alone are dropped
  // cell_ctrl_clear is absent here on purpose, so a cell reset cannot disturb routing
  always @* begin
    nxt_first_data_source_select  = first_data_source_select_ff;
    nxt_second_data_source_select = second_data_source_select_ff;
    if (wr_en && sel_low_hit && pstrb[0]) begin
      nxt_first_data_source_select  = pwdata[`LCIS_D1_MSB:`LCIS_D1_LSB];
      nxt_second_data_source_select = pwdata[`LCIS_D2_MSB:`LCIS_D2_LSB];
    end
  end

  // only presetn counts as power-on; fields keep their value over any other reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_data_source_select_ff  <= `LCIS_POR_FIELD;
      second_data_source_select_ff <= `LCIS_POR_FIELD;
    end else begin
      first_data_source_select_ff  <= nxt_first_data_source_select;
      second_data_source_select_ff <= nxt_second_data_source_select;
    end
  end

  // sticky note that a cell reset went by; a new event beats a clearing read
  // clear only after a read that showed the flag set: prdata is captured in setup,
  // so an event landing during that setup would otherwise be lost
  always @* begin
    nxt_ctrl_clear_seen = ctrl_clear_seen_ff;
    if (cell_ctrl_clear) begin
      nxt_ctrl_clear_seen = 1'h1;
    end else if (rd_en && status_hit && prdata_ff[0]) begin
      nxt_ctrl_clear_seen = 1'h0;
    end
  end

  // status flag register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_clear_seen_ff <= `LCIS_FLAG_RST;
    end else begin
      ctrl_clear_seen_ff <= nxt_ctrl_clear_seen;
    end
  end

  // unimplemented bits 7 and 3 tie low
  assign data_input_select_low = {1'h0, second_data_source_select_ff, 1'h0, first_data_source_select_ff};

  // read data picked in the setup cycle and held until the next read setup,
  // so the value is settled for the whole access phase
  always @* begin
    nxt_prdata = prdata_ff;
    if (rd_setup) begin
      if (sel_low_hit) begin
        nxt_prdata = {24'h00_0000, data_input_select_low};
      end else if (status_hit) begin
        nxt_prdata = {31'h0000_0000, ctrl_clear_seen_ff};
      end else begin
        nxt_prdata = `LCIS_RDATA_RST;
      end
    end
  end

  // read data register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= `LCIS_RDATA_RST;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // port driven straight from the flip-flop
  assign prdata = prdata_ff;

  // selection is pure combinational, no latency from input to output
  // the cell inputs may toggle between clock edges; nothing here retimes them
  assign first_line_idx    = first_line(first_data_source_select_ff);
  assign second_line_idx   = second_line(second_data_source_select_ff);
  assign selected_data_one = pick_line(cell_input_bus, first_line_idx);
  assign selected_data_two = pick_line(cell_input_bus, second_line_idx);

endmodule

// >>> src/lcis_regs.vh
`ifndef LCIS_REGS_VH
`define LCIS_REGS_VH

// register byte address on the apb bus
`define LCIS_SEL_LOW_ADDR   12'h000
// status word: reset kind seen since last read
`define LCIS_STATUS_ADDR    12'h004

// field positions inside the select register
`define LCIS_D1_LSB         0
`define LCIS_D1_MSB         2
`define LCIS_D2_LSB         4
`define LCIS_D2_MSB         6
`define LCIS_GAP_BIT        3
`define LCIS_TOP_BIT        7

// base input line of each selector
`define LCIS_D1_BASE        5'h00
`define LCIS_D2_BASE        5'h04

// value loaded into the fields at power-on, arbitrary stand-in for unknown
`define LCIS_POR_FIELD      3'h0

// read data and status flag after power-on reset
`define LCIS_RDATA_RST      32'h0000_0000
`define LCIS_FLAG_RST       1'h0

`endif

// >>> sim/lcis_select_checker.sv
module lcis_select_checker (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // cell side
  input wire logic        cell_ctrl_clear,
  input wire logic [15:0] cell_input_bus,
  input wire logic        selected_data_one,
  input wire logic        selected_data_two
);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of both fields, so no design internals are needed
  logic [6:0] sh_ff;
  wire [2:0]  c1 = sh_ff[2:0];
  wire [2:0]  c2 = sh_ff[6:4];
  wire        rd_setup = psel && !penable && !pwrite && paddr == 12'h000;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) sh_ff <= 7'h00;
    else if (psel && penable && pwrite && paddr == 12'h000 && pstrb[0]) sh_ff <= pwdata[6:0] & 7'h77;
  top_zero_a: assert property (prdata[7] == 1'h0) else $error("bit 7 set");
  gap_zero_a: assert property (prdata[3] == 1'h0) else $error("bit 3 set");
  one_high_a: assert property (c1 > 3'h2 |-> selected_data_one == cell_input_bus[c1]) else $error("d1 hi");
  one_low_a: assert property (c1 < 3'h3 |-> selected_data_one == cell_input_bus[c1]) else $error("d1 lo");
  two_sel_a: assert property (selected_data_two == cell_input_bus[c2 + 4'h4]) else $error("d2");
  read_back_a: assert property (rd_setup |=> prdata == sh_ff) else $error("read");
  clear_keep_a: assert property (cell_ctrl_clear ##1 rd_setup |=> prdata == sh_ff) else $error("clear");
  cover property (sh_ff == 7'h77);
  cover property (cell_ctrl_clear);
  cover property (rd_setup);
endmodule
bind lcis_select lcis_select_checker chk_u (.*);

// >>> sim/tb_lcis_select.sv
module tb_lcis_select;
  timeunit 1ns; timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cell_ctrl_clear = 0, pready, pslverr, s1, s2, er;
  logic [3:0] pstrb = 4'hf;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] bus = 0;
  int err_total = 0, checks_done = 0;
  always #20 pclk = ~pclk;
  lcis_select dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .cell_ctrl_clear, .cell_input_bus(bus), .selected_data_one(s1), .selected_data_two(s2));
  task chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin err_total++; $display("BAD %0t %h %h", $time, g, e); end
  endtask
  // one transfer, entered just after a rising edge; data and error taken at the pready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task finish_test;
    $display("checks %0d bad %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin #20000; err_total++; finish_test; end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    // fields come out of power-on at the chosen code 000
    apb(0, 0, 0, rd, er); chk(rd, 0);
    // every code in both fields, gap and top bits written as ones
    for (int i = 0; i < 8; i++) begin
      apb(1, 0, 32'hff88 | i << 4 | i, rd, er); chk(er, 0);
      apb(0, 0, 0, rd, er); chk(rd, i << 4 | i);
      bus <= 16'h1 << i; @(posedge pclk); chk({s1, s2}, 2);
      bus <= 16'h1 << i + 4; @(posedge pclk); chk({s1, s2}, 1);
    end
    $display("test select done");
    // a write without lane 0 strobed leaves the fields alone
    pstrb <= 4'he;
    apb(1, 0, 32'h0000_0011, rd, er);
    pstrb <= 4'hf;
    apb(0, 0, 0, rd, er); chk(rd, 'h77);
    cell_ctrl_clear <= 1; @(posedge pclk) cell_ctrl_clear <= 0;
    apb(0, 0, 0, rd, er); chk(rd, 'h77);
    apb(0, 'h4, 0, rd, er); chk(rd, 1);
    apb(0, 'h4, 0, rd, er); chk(rd, 0);
    apb(0, 'h8, 0, rd, er); chk(rd, 0); chk(er, 1);
    apb(0, 0, 0, rd, er); chk(er, 0);
    $display("test clear done");
    finish_test;
  end
endmodule
